/* flspol_defines.svh */
// Constants of the flash status polling controller
`ifndef FLSPOL_DEFINES_SVH
`define FLSPOL_DEFINES_SVH
// ***********************************
// Register offsets and reset values
// ***********************************
`define FLSPOL_OFF_CTRL 5'h00
`define FLSPOL_OFF_ADDR 5'h04
`define FLSPOL_OFF_DATA 5'h08
`define FLSPOL_OFF_STAT 5'h0c
`define FLSPOL_OFF_RDAT 5'h10
`define FLSPOL_ADDR_RST 32'h0000_0000
`define FLSPOL_DATA_RST 32'h0000_0000
// ***********************************
// Control and status fields
// ***********************************
`define FLSPOL_CTRL_START 0
`define FLSPOL_CTRL_OP_LSB 1
`define FLSPOL_CTRL_OP_MSB 3
`define FLSPOL_ST_BUSY 0
`define FLSPOL_ST_DONE 1
`define FLSPOL_ST_FAIL 2
`define FLSPOL_ST_ERRLOCK 3
`define FLSPOL_ST_ABTLOCK 4
`define FLSPOL_ST_REFUSED 5
`define FLSPOL_ST_RDYBSY 6
`define FLSPOL_ST_ETIMER 7
`define FLSPOL_ST_BYTE_LSB 8
// ***********************************
// Flash status byte, address width, commands and bus timing
// ***********************************
`define FLSPOL_DQ_POLL 7
`define FLSPOL_DQ_TOGGLE 6
`define FLSPOL_DQ_ERROR 5
`define FLSPOL_DQ_ETIMER 3
`define FLSPOL_DQ_ABORT 1
`define FLSPOL_AW 27
`define FLSPOL_CMD_RDRST 16'h00f0
`define FLSPOL_UNLK1_ADDR 27'h000_0555
`define FLSPOL_UNLK1_DATA 16'h00aa
`define FLSPOL_UNLK2_ADDR 27'h000_02aa
`define FLSPOL_UNLK2_DATA 16'h0055
`define FLSPOL_PHASE_CYC 4
`define FLSPOL_RST_CYC 20
`endif

/* flspol_pkg.sv */
// Types of the flash status polling controller
package flspol_pkg;
   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_POLL_DATA, OP_POLL_TOGGLE,
      OP_READ_RESET, OP_ABORT_RESET, OP_PIN_RESET, OP_NONE
   } flspol_op_type;
   typedef struct packed {
      logic chipEnN;
      logic outEnN;
      logic wrEnN;
      logic [26:0] addr;
   } flspol_pins_type;
   typedef struct packed {
      logic write;
      logic [26:0] addr;
      logic [15:0] data;
   } flspol_req_type;
endpackage : flspol_pkg

/* flspol_cycle.sv */
// One asynchronous flash bus read or write cycle
`timescale 1ns/1ps
`include "flspol_defines.svh"
module flspol_cycle import flspol_pkg::*; #(
   parameter int PHASE_CYC = `FLSPOL_PHASE_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire flspol_req_type req,
   input wire logic reqValid,
   output logic reqReady,
   output logic done,
   output logic [15:0] rdData,
   output flspol_pins_type pins,
   output logic [15:0] dqOut,
   output logic dqOe,
   input wire logic [15:0] dqIn
);
   typedef enum {C_IDLE, C_SETUP, C_STROBE, C_HOLD} flspol_cstate_type;
   flspol_cstate_type stateReg;
   logic [7:0] cntReg;
   logic writeReg;
   logic phaseEnd;

   if (PHASE_CYC < 1 || PHASE_CYC > 255)
   begin : g_check
      $error("PHASE_CYC out of range");
   end

   assign reqReady = (stateReg == C_IDLE);
   assign phaseEnd = (cntReg == 8'(PHASE_CYC - 1));

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         stateReg <= C_IDLE;
         cntReg <= 8'h00;
         writeReg <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         cntReg <= phaseEnd ? 8'h00 : cntReg + 8'h01;
         case (stateReg)
            C_IDLE:
            begin
               cntReg <= 8'h00;
               if (reqValid)
               begin
                  stateReg <= C_SETUP;
                  writeReg <= req.write;
               end
            end
            C_SETUP: if (phaseEnd) stateReg <= C_STROBE;
            C_STROBE: if (phaseEnd) stateReg <= C_HOLD;
            C_HOLD:
            begin
               if (phaseEnd)
               begin
                  stateReg <= C_IDLE;
                  done <= 1'b1;
               end
            end
            default: stateReg <= C_IDLE;
         endcase
      end
   end

   // Pin drive; data held from setup through hold on writes
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pins <= '{chipEnN: 1'b1, outEnN: 1'b1, wrEnN: 1'b1, addr: '0};
         dqOut <= 16'h0000;
         dqOe <= 1'b0;
      end
      else if (stateReg == C_IDLE && reqValid)
      begin
         pins.chipEnN <= 1'b0;
         pins.addr <= req.addr;
         dqOut <= req.data;
         dqOe <= req.write;
      end
      else if (stateReg == C_SETUP && phaseEnd)
      begin
         pins.outEnN <= writeReg;
         pins.wrEnN <= !writeReg;
      end
      else if (stateReg == C_STROBE && phaseEnd)
      begin
         pins.chipEnN <= 1'b1;
         pins.outEnN <= 1'b1;
         pins.wrEnN <= 1'b1;
      end
      else if (stateReg == C_HOLD && phaseEnd)
      begin
         dqOe <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdData <= 16'h0000;
      else if (stateReg == C_STROBE && phaseEnd && !writeReg)
         rdData <= dqIn;
   end

   // ***********************************
   // Assertions
   // ***********************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_read_strobe_pins: assert property (!pins.outEnN |-> !pins.chipEnN && pins.wrEnN)
      else $error("read strobe without chip enable");
   a_write_oe_high: assert property (!pins.wrEnN |-> pins.outEnN && dqOe)
      else $error("write strobe with output enable low");
   a_dq_released: assert property (!pins.outEnN |-> !dqOe)
      else $error("host drives data during read");
   a_done_single: assert property (done |=> !done && reqReady)
      else $error("done not a single pulse");
endmodule : flspol_cycle

/* flspol_host.sv */
// Host controller polling a parallel flash for program/erase status
`timescale 1ns/1ps
`include "flspol_defines.svh"
module flspol_host import flspol_pkg::*; #(
   parameter int PHASE_CYC = `FLSPOL_PHASE_CYC,
   parameter int RST_CYC = `FLSPOL_RST_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [4:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [4:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic chipEnableN,
   output logic outputEnableN,
   output logic writeEnableN,
   output logic resetN,
   output logic [26:0] flashAddr,
   output logic [15:0] dqOut,
   output logic dqOe,
   input wire logic [15:0] dqIn,
   input wire logic readyBusyN
);
   typedef enum {S_IDLE, S_ISSUE, S_WAIT, S_PINRST} flspol_state_type;

   if (RST_CYC < 1 || RST_CYC > 65535)
   begin : g_check
      $error("RST_CYC out of range");
   end

   function automatic logic [2:0] decodeOffset(input logic [4:0] a);
      case (a)
         `FLSPOL_OFF_CTRL: decodeOffset = 3'h0;
         `FLSPOL_OFF_ADDR: decodeOffset = 3'h1;
         `FLSPOL_OFF_DATA: decodeOffset = 3'h2;
         `FLSPOL_OFF_STAT: decodeOffset = 3'h3;
         `FLSPOL_OFF_RDAT: decodeOffset = 3'h4;
         default: decodeOffset = 3'h7;
      endcase
   endfunction : decodeOffset

   function automatic logic [31:0] mergeLanes(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      for (int i = 0; i < 4; i++)
         mergeLanes[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
   endfunction : mergeLanes

   flspol_state_type stateReg;
   flspol_op_type opReg;
   flspol_op_type newOp;
   flspol_req_type cycReq;
   flspol_pins_type cycPins;
   logic [31:0] addrReg, dataReg, statusWord;
   logic [15:0] lastReg, cycData, rstCntReg;
   logic [7:0] prevReg, b;
   logic [1:0] stepReg, evStep;
   logic phaseReg, evPhase, evFinish, evFail;
   logic cycReady, cycDone, doneFlag, failFlag, refusedFlag;
   logic errorLock, abortLock;
   logic wrFire, wrCtrl, allowed, startOk, startBad, finish;
   logic [2:0] wrSel;

   // ***********************************
   // AXI4-Lite slave
   // ***********************************
   assign awready = awvalid && wvalid && !bvalid;
   assign wready = awready;
   assign wrFire = awready;
   assign arready = !rvalid;
   assign wrSel = decodeOffset(awaddr);
   assign newOp = flspol_op_type'(wdata[`FLSPOL_CTRL_OP_MSB:`FLSPOL_CTRL_OP_LSB]);
   assign wrCtrl = wrFire && wrSel == 3'h0 && wstrb[0] && wdata[`FLSPOL_CTRL_START];
   // Locks admit only their clearing command or a pin reset
   assign allowed = stateReg == S_IDLE && newOp != OP_NONE
      && (!errorLock || newOp == OP_READ_RESET || newOp == OP_PIN_RESET)
      && (!abortLock || newOp == OP_ABORT_RESET || newOp == OP_PIN_RESET);
   assign startOk = wrCtrl && allowed;
   assign startBad = wrCtrl && !allowed;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bvalid <= 1'b0;
         bresp <= 2'b00;
      end
      else if (wrFire)
      begin
         bvalid <= 1'b1;
         bresp <= (wrSel == 3'h7) ? 2'b10 : 2'b00;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         addrReg <= `FLSPOL_ADDR_RST;
         dataReg <= `FLSPOL_DATA_RST;
      end
      else if (wrFire && wrSel == 3'h1)
         addrReg <= mergeLanes(addrReg, wdata, wstrb);
      else if (wrFire && wrSel == 3'h2)
         dataReg <= mergeLanes(dataReg, wdata, wstrb);
   end

   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[`FLSPOL_ST_BUSY] = (stateReg != S_IDLE);
      statusWord[`FLSPOL_ST_DONE] = doneFlag;
      statusWord[`FLSPOL_ST_FAIL] = failFlag;
      statusWord[`FLSPOL_ST_ERRLOCK] = errorLock;
      statusWord[`FLSPOL_ST_ABTLOCK] = abortLock;
      statusWord[`FLSPOL_ST_REFUSED] = refusedFlag;
      statusWord[`FLSPOL_ST_RDYBSY] = readyBusyN;
      statusWord[`FLSPOL_ST_ETIMER] = lastReg[`FLSPOL_DQ_ETIMER];
      statusWord[`FLSPOL_ST_BYTE_LSB +: 8] = lastReg[7:0];
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp <= 2'b00;
         case (decodeOffset(araddr))
            3'h0: rdata <= {28'h0000000, opReg, 1'b0};
            3'h1: rdata <= addrReg;
            3'h2: rdata <= dataReg;
            3'h3: rdata <= statusWord;
            3'h4: rdata <= {16'h0000, lastReg};
            default:
            begin
               rdata <= 32'h0000_0000;
               rresp <= 2'b10;
            end
         endcase
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   // ***********************************
   // Operation sequencer
   // ***********************************
   assign b = cycData[7:0];

   // Evaluate each completed flash cycle; only defined bits are looked at
   always_comb
   begin
      evFinish = 1'b0;
      evFail = 1'b0;
      evPhase = phaseReg;
      evStep = stepReg + 2'd1;
      case (opReg)
         OP_POLL_DATA:
         begin
            evStep = 2'd0;
            if (b[`FLSPOL_DQ_POLL] == dataReg[`FLSPOL_DQ_POLL])
               evFinish = 1'b1;
            else if (phaseReg)
            begin
               evFinish = 1'b1;
               evFail = 1'b1;
            end
            else if (b[`FLSPOL_DQ_ERROR] || b[`FLSPOL_DQ_ABORT])
               evPhase = 1'b1;
         end
         OP_POLL_TOGGLE:
         begin
            if (stepReg != 2'd0)
            begin
               evStep = 2'd0;
               if (prevReg[`FLSPOL_DQ_TOGGLE] == b[`FLSPOL_DQ_TOGGLE])
                  evFinish = 1'b1;
               else if (phaseReg)
               begin
                  evFinish = 1'b1;
                  evFail = 1'b1;
               end
               else if (b[`FLSPOL_DQ_ERROR] || b[`FLSPOL_DQ_ABORT])
                  evPhase = 1'b1;
            end
         end
         OP_ABORT_RESET: evFinish = (stepReg == 2'd2);
         default: evFinish = 1'b1;
      endcase
   end

   assign finish = stateReg == S_WAIT && cycDone && evFinish;

   // Poll reads target the address software set up as valid
   always_comb
   begin
      cycReq = '{write: 1'b0, addr: addrReg[26:0], data: dataReg[15:0]};
      case (opReg)
         OP_WRITE: cycReq.write = 1'b1;
         OP_READ_RESET:
         begin
            cycReq.write = 1'b1;
            cycReq.data = `FLSPOL_CMD_RDRST;
         end
         OP_ABORT_RESET:
         begin
            cycReq.write = 1'b1;
            cycReq.addr = (stepReg == 2'd1) ? `FLSPOL_UNLK2_ADDR : `FLSPOL_UNLK1_ADDR;
            case (stepReg)
               2'd0: cycReq.data = `FLSPOL_UNLK1_DATA;
               2'd1: cycReq.data = `FLSPOL_UNLK2_DATA;
               default: cycReq.data = `FLSPOL_CMD_RDRST;
            endcase
         end
         default: cycReq.write = 1'b0;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         stateReg <= S_IDLE;
         opReg <= OP_NONE;
         stepReg <= 2'd0;
         phaseReg <= 1'b0;
         rstCntReg <= 16'h0000;
      end
      else
      begin
         case (stateReg)
            S_IDLE:
            begin
               if (startOk)
               begin
                  opReg <= newOp;
                  stepReg <= 2'd0;
                  phaseReg <= 1'b0;
                  rstCntReg <= 16'(RST_CYC - 1);
                  stateReg <= (newOp == OP_PIN_RESET) ? S_PINRST : S_ISSUE;
               end
            end
            S_ISSUE: if (cycReady) stateReg <= S_WAIT;
            S_WAIT:
            begin
               if (cycDone)
               begin
                  stepReg <= evStep;
                  phaseReg <= evPhase;
                  stateReg <= evFinish ? S_IDLE : S_ISSUE;
               end
            end
            S_PINRST:
            begin
               rstCntReg <= rstCntReg - 16'h0001;
               if (rstCntReg == 16'h0000)
                  stateReg <= S_IDLE;
            end
            default: stateReg <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         prevReg <= 8'h00;
         lastReg <= 16'h0000;
      end
      else if (cycDone)
      begin
         prevReg <= b;
         lastReg <= cycData;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         doneFlag <= 1'b0;
         failFlag <= 1'b0;
         refusedFlag <= 1'b0;
      end
      else
      begin
         if (startOk)
         begin
            doneFlag <= 1'b0;
            failFlag <= 1'b0;
            refusedFlag <= 1'b0;
         end
         else if (startBad)
            refusedFlag <= 1'b1;
         if (finish || (stateReg == S_PINRST && rstCntReg == 16'h0000))
         begin
            doneFlag <= 1'b1;
            failFlag <= finish && evFail;
         end
      end
   end

   // Error and abort locks; set is taken before any clear
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         errorLock <= 1'b0;
         abortLock <= 1'b0;
      end
      else if (finish && evFail)
      begin
         errorLock <= errorLock || b[`FLSPOL_DQ_ERROR];
         abortLock <= abortLock || b[`FLSPOL_DQ_ABORT];
      end
      else if (stateReg == S_PINRST)
      begin
         errorLock <= 1'b0;
         abortLock <= 1'b0;
      end
      else if (finish && opReg == OP_READ_RESET)
         errorLock <= 1'b0;
      else if (finish && opReg == OP_ABORT_RESET)
         abortLock <= 1'b0;
   end

   // Reset pin held low for the whole pin reset
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         resetN <= 1'b0;
      else
         resetN <= !(startOk && newOp == OP_PIN_RESET)
            && !(stateReg == S_PINRST && rstCntReg != 16'h0000);
   end

   flspol_cycle #(.PHASE_CYC(PHASE_CYC)) u_cycle (
      .clock(clock),
      .rst(rst),
      .req(cycReq),
      .reqValid(stateReg == S_ISSUE),
      .reqReady(cycReady),
      .done(cycDone),
      .rdData(cycData),
      .pins(cycPins),
      .dqOut(dqOut),
      .dqOe(dqOe),
      .dqIn(dqIn)
   );

   assign chipEnableN = cycPins.chipEnN;
   assign outputEnableN = cycPins.outEnN;
   assign writeEnableN = cycPins.wrEnN;
   assign flashAddr = cycPins.addr;

   // ***********************************
   // Assertions
   // ***********************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_error_lock_refuse: assert property (errorLock && wrCtrl && stateReg == S_IDLE
      && newOp != OP_READ_RESET && newOp != OP_PIN_RESET |=> refusedFlag && stateReg == S_IDLE)
      else $error("command accepted while error lock set");
   a_abort_lock_refuse: assert property (abortLock && wrCtrl && stateReg == S_IDLE
      && newOp != OP_ABORT_RESET && newOp != OP_PIN_RESET |=> refusedFlag && stateReg == S_IDLE)
      else $error("command accepted while abort lock set");
   a_pin_reset_idle: assert property (stateReg == S_PINRST |-> chipEnableN && outputEnableN
      && writeEnableN)
      else $error("bus strobed during pin reset");
   a_poll_match_pass: assert property (stateReg == S_WAIT && cycDone && opReg == OP_POLL_DATA
      && b[7] == dataReg[7] |=> doneFlag && !failFlag && stateReg == S_IDLE)
      else $error("poll match did not pass");
   a_toggle_fail_lock: assert property (stateReg == S_WAIT && cycDone && evFail
      && b[`FLSPOL_DQ_ERROR] |=> failFlag && errorLock)
      else $error("failed toggle poll without error lock");
   a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_read_reset_cmd: assert property (stateReg == S_WAIT && opReg == OP_READ_RESET
      && !writeEnableN |-> dqOut == `FLSPOL_CMD_RDRST)
      else $error("read reset command data wrong");

   c_poll_pass: cover property (finish && opReg == OP_POLL_DATA && !evFail);
   c_toggle_fail: cover property (finish && opReg == OP_POLL_TOGGLE && evFail);
   c_abort_done: cover property (finish && opReg == OP_ABORT_RESET);
   c_refused: cover property (startBad);
endmodule : flspol_host

/* flspol_flash_model.sv */
// Behavioural parallel flash that answers status polls
`timescale 1ns/1ps
module flspol_flash_model (
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic rstN,
   input wire logic [26:0] addr,
   input wire logic [15:0] wrData,
   output logic [15:0] dq,
   output logic drive,
   output logic rdyBsyN
);
   // ****
   // Operation state, set by the bench
   // ****
   int busyLeft = 0;
   logic failMode = 0;
   logic abortMode = 0;
   logic eraseMode = 0;
   logic progBit = 1;
   logic togReg = 0;
   logic altReg = 0;
   logic suspendMode = 0;
   logic armed = 0;
   logic [15:0] outReg = 16'h0000;
   logic [26:0] wrAddr = 27'h0000000;
   logic [15:0] wrWord = 16'h0000;
   assign drive = !ceN && !oeN && rstN;
   assign dq = drive ? outReg : ~outReg;
   assign rdyBsyN = !(busyLeft > 0);
   always @(negedge oeN)
      if (!ceN && rstN)
      begin
         // Suspended erase of block 0: poll bit 1, primary toggle frozen
         if (suspendMode && addr[26:16] == 11'h000)
         begin
            altReg = ~altReg;
            outReg = {8'h00, 1'b1, togReg, 3'b000, altReg, 2'b00};
         end
         else if (busyLeft > 0 || failMode || abortMode)
         begin
            togReg = ~togReg;
            outReg = {8'h00, !eraseMode && !progBit, togReg, failMode, 1'b0, eraseMode,
               togReg && eraseMode, abortMode, 1'b0};
            if (busyLeft > 0)
               busyLeft--;
         end
         else
            outReg = {8'h00, progBit, 7'h00};
      end
   // Address on the later fall, data on the earlier rise of the two strobes
   always @(ceN or weN)
      if (!ceN && !weN && rstN)
      begin
         armed = 1;
         wrAddr = addr;
      end
      else if (armed)
      begin
         armed = 0;
         wrWord = wrData;
         if (wrData == 16'h00f0)
         begin
            failMode = 0;
            abortMode = 0;
         end
      end
   always @(negedge rstN)
   begin
      failMode = 0;
      abortMode = 0;
      busyLeft = 0;
   end
endmodule : flspol_flash_model

/* test_flash_status_polling.sv */
// Testbench of the flash status polling controller
`timescale 1ns/1ps
`include "flspol_defines.svh"
module test_flash_status_polling;
   logic clock = 0;
   logic rst = 1;
   logic [4:0] awaddr = 0;
   logic [4:0] araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic ceN, oeN, weN, resetN, dqOe, rdyBsyN;
   logic [26:0] flashAddr;
   logic [15:0] dqOut, modelDq, dqIn;
   int err_total = 0;
   int checked = 0;
   int lowCnt = 0;
   int lowBase = 0;
   assign dqIn = dqOe ? dqOut : modelDq;
   flspol_host #(.PHASE_CYC(1), .RST_CYC(3)) flspol_host_i (.clock(clock), .rst(rst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .chipEnableN(ceN), .outputEnableN(oeN),
      .writeEnableN(weN), .resetN(resetN), .flashAddr(flashAddr), .dqOut(dqOut),
      .dqOe(dqOe), .dqIn(dqIn), .readyBusyN(rdyBsyN));
   flspol_flash_model flspol_flash_model_i (.ceN(ceN), .oeN(oeN), .weN(weN), .rstN(resetN),
      .addr(flashAddr), .wrData(dqOut), .dq(modelDq), .drive(), .rdyBsyN(rdyBsyN));
   // ****
   // Clock, watchdog and bus tasks
   // ****
   initial
   begin
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock)
      if (!resetN)
         lowCnt <= lowCnt + 1;
   initial
   begin
      #200000;
      err_total++;
      close_out();
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic axw(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do @(negedge clock); while (!(awready && wready));
      @(posedge clock);
      awvalid <= 0;
      wvalid <= 0;
      while (!bvalid) @(negedge clock);
      @(posedge clock);
      rs = bresp;
      bready <= 0;
   endtask : axw
   task automatic axr(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(negedge clock); while (!arready);
      @(posedge clock);
      arvalid <= 0;
      while (!rvalid) @(negedge clock);
      @(posedge clock);
      v = rdata;
      rs = rresp;
      rready <= 0;
   endtask : axr
   task automatic runOp(input logic [2:0] op, output logic [31:0] st);
      axw(`FLSPOL_OFF_CTRL, {28'h0000000, op, 1'b1}, r);
      do axr(`FLSPOL_OFF_STAT, st, r); while (st[0] !== 1'b0);
   endtask : runOp
   task close_out;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   // ****
   // Tests
   // ****
   initial
   begin
      repeat (16) @(posedge clock);
      chk("reset pin", {31'h0, resetN}, 32'h0);
      chk("chip enable", {31'h0, ceN}, 32'h1);
      rst <= 0;
      repeat (2) @(posedge clock);
      axr(`FLSPOL_OFF_STAT, d, r);
      chk("status idle", d & 32'h7f, 32'h40);
      axr(5'h14, d, r);
      chk("unmapped read", {30'h0, r}, 32'h2);
      axw(5'h18, 0, r);
      chk("unmapped write", {30'h0, r}, 32'h2);
      $display("test reset done");
      axw(`FLSPOL_OFF_ADDR, 32'h123, r);
      axw(`FLSPOL_OFF_DATA, 32'h80, r);
      flspol_flash_model_i.busyLeft = 3;
      runOp(3'd2, d);
      chk("program poll", d & 32'h3f, 32'h02);
      chk("status byte", {24'h0, d[15:8]}, 32'h80);
      axr(`FLSPOL_OFF_RDAT, d, r);
      chk("read data", d, 32'h0080);
      $display("test program done");
      flspol_flash_model_i.eraseMode = 1;
      flspol_flash_model_i.busyLeft = 4;
      runOp(3'd3, d);
      chk("erase toggle", d & 32'h3f, 32'h02);
      flspol_flash_model_i.eraseMode = 0;
      $display("test erase done");
      flspol_flash_model_i.suspendMode = 1;
      runOp(3'd3, d);
      chk("suspend toggle", d & 32'h3f, 32'h02);
      runOp(3'd2, d);
      chk("suspend poll", d & 32'h803f, 32'h8002);
      axw(`FLSPOL_OFF_ADDR, 32'h10123, r);
      runOp(3'd0, d);
      axr(`FLSPOL_OFF_RDAT, d, r);
      chk("suspend other block", d, 32'h0080);
      flspol_flash_model_i.suspendMode = 0;
      $display("test suspend done");
      flspol_flash_model_i.failMode = 1;
      flspol_flash_model_i.busyLeft = 2;
      runOp(3'd3, d);
      chk("error fail", d & 32'h3f, 32'h0e);
      axw(`FLSPOL_OFF_CTRL, 32'h5, r);
      axr(`FLSPOL_OFF_STAT, d, r);
      chk("error refuse", d & 32'h3f, 32'h2e);
      runOp(3'd4, d);
      chk("read reset", d & 32'h3f, 32'h02);
      $display("test error done");
      flspol_flash_model_i.abortMode = 1;
      flspol_flash_model_i.busyLeft = 1;
      runOp(3'd2, d);
      chk("abort fail", d & 32'h3f, 32'h16);
      runOp(3'd5, d);
      chk("abort reset", d & 32'h3f, 32'h02);
      $display("test abort done");
      lowBase = lowCnt;
      runOp(3'd6, d);
      chk("pin reset", d & 32'h3f, 32'h02);
      chk("pin low span", lowCnt - lowBase, 32'd3);
      axw(`FLSPOL_OFF_CTRL, 32'hf, r);
      axr(`FLSPOL_OFF_STAT, d, r);
      chk("bad op", d & 32'h21, 32'h20);
      axw(`FLSPOL_OFF_ADDR, 32'habc, r);
      axw(`FLSPOL_OFF_DATA, 32'h1234, r);
      runOp(3'd1, d);
      chk("write addr", {5'h0, flspol_flash_model_i.wrAddr}, 32'habc);
      chk("write data", {16'h0, flspol_flash_model_i.wrWord}, 32'h1234);
      $display("test write done");
      close_out();
   end
endmodule : test_flash_status_polling
